// file: hw/iie_exec.sv
// execution of the two increment instructions of the core
`timescale 1ns/1ns
`default_nettype none
module iie_exec
  import iie_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  // file register read data for the addressed register
  input wire logic [DATA_W-1:0] file_rdata,
  // file register read address
  output logic [ADDR_W-1:0] file_raddr,
  // file register write port
  output logic file_we,
  output logic [ADDR_W-1:0] file_waddr,
  output logic [DATA_W-1:0] file_wdata,
  // accumulator write port
  output logic acc_we,
  output logic [DATA_W-1:0] acc_wdata,
  // zero flag update
  output logic zero_we,
  output logic zero_val,
  // prefetched word discarded, nop cycle runs
  output logic skip_nop,
  // instruction busy for a second cycle
  output logic busy
);
  //==========================================================
  // local constants
  // step added to the operand
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  // all-zero data value, the skip and zero flag test
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  // idle level of every one-bit strobe
  localparam logic STROBE_IDLE = 1'h0;

  //==========================================================
  // helper functions
  // opcode field of an instruction word
  function automatic logic [OPC_MSB-OPC_LSB:0] opc_of(input logic [INSTR_W-1:0] word);
    return word[OPC_MSB:OPC_LSB];
  endfunction

  // destination select bit of an instruction word
  function automatic logic dest_of(input logic [INSTR_W-1:0] word);
    return word[DEST_BIT];
  endfunction

  // file register address field of an instruction word
  function automatic logic [ADDR_W-1:0] addr_of(input logic [INSTR_W-1:0] word);
    return word[ADDR_W-1:0];
  endfunction

  // increment on the 8-bit path; the carry out is dropped on purpose
  function automatic logic [DATA_W-1:0] inc_wrap(input logic [DATA_W-1:0] value);
    return value + DATA_ONE;
  endfunction

  // true when a data value is all zeros
  function automatic logic is_zero(input logic [DATA_W-1:0] value);
    return (value == DATA_ZERO);
  endfunction

  //==========================================================
  // registers behind the outputs
  // file write strobe
  logic file_we_q;
  logic file_we_d;
  // file write address
  logic [ADDR_W-1:0] file_waddr_q;
  logic [ADDR_W-1:0] file_waddr_d;
  // file write data
  logic [DATA_W-1:0] file_wdata_q;
  logic [DATA_W-1:0] file_wdata_d;
  // accumulator write strobe
  logic acc_we_q;
  logic acc_we_d;
  // accumulator write data
  logic [DATA_W-1:0] acc_wdata_q;
  logic [DATA_W-1:0] acc_wdata_d;
  // zero flag load strobe
  logic zero_we_q;
  logic zero_we_d;
  // zero flag value
  logic zero_val_q;
  logic zero_val_d;
  // discard marker for the prefetched word
  logic skip_q;
  logic skip_d;
  // second cycle of a skipping instruction
  logic busy_q;
  logic busy_d;

  //==========================================================
  // decode
  // opcode bits of the issued word
  wire [OPC_MSB-OPC_LSB:0] opc_field = opc_of(instr_word);
  // destination select of the issued word
  wire dest_field = dest_of(instr_word);
  // file address of the issued word
  wire [ADDR_W-1:0] addr_field = addr_of(instr_word);
  // a word shown while the skip runs is the discarded one
  wire word_live = instr_valid && !skip_q;
  // plain increment detected
  wire is_inc = word_live && (opc_field == OPC_INC);
  // increment with skip detected
  wire is_inc_skip = word_live && (opc_field == OPC_INC_SKIP);
  // either increment form
  wire is_any = is_inc || is_inc_skip;

  //==========================================================
  // data path
  // sum wraps on the 8-bit path
  wire [DATA_W-1:0] sum = inc_wrap(file_rdata);
  // all-ones operand gives zero here
  wire res_zero = is_zero(sum);
  // skip form with a zero result drops the next word
  wire take_skip = is_inc_skip && res_zero;

  //==========================================================
  // next values
  // destination one: back to the same file
  assign file_we_d = is_any && dest_field;
  // same address that was read
  assign file_waddr_d = addr_field;
  // incremented value for the file
  assign file_wdata_d = sum;
  // destination zero: accumulator, file left alone
  assign acc_we_d = is_any && !dest_field;
  // incremented value for the accumulator
  assign acc_wdata_d = sum;
  // only the plain form touches the zero flag
  assign zero_we_d = is_inc;
  // zero flag follows the wrapped result
  assign zero_val_d = res_zero;
  // zero result kills the next word for one cycle
  assign skip_d = take_skip;
  // the nop cycle makes the skip form two cycles long
  assign busy_d = take_skip;

  //==========================================================
  // file write strobe register
  always_ff @(posedge clk) begin
    if (rst) begin
      file_we_q <= STROBE_IDLE;
    end else begin
      file_we_q <= file_we_d;
    end
  end

  // file write address register
  always_ff @(posedge clk) begin
    if (rst) begin
      file_waddr_q <= ADDR_RST;
    end else begin
      file_waddr_q <= file_waddr_d;
    end
  end

  // file write data register
  always_ff @(posedge clk) begin
    if (rst) begin
      file_wdata_q <= DATA_RST;
    end else begin
      file_wdata_q <= file_wdata_d;
    end
  end

  // accumulator strobe register
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_we_q <= STROBE_IDLE;
    end else begin
      acc_we_q <= acc_we_d;
    end
  end

  // accumulator data register
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_wdata_q <= DATA_RST;
    end else begin
      acc_wdata_q <= acc_wdata_d;
    end
  end

  // zero flag strobe register
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_we_q <= STROBE_IDLE;
    end else begin
      zero_we_q <= zero_we_d;
    end
  end

  // zero flag value register
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_val_q <= STROBE_IDLE;
    end else begin
      zero_val_q <= zero_val_d;
    end
  end

  // skip marker register; lasts exactly one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_q <= STROBE_IDLE;
    end else begin
      skip_q <= skip_d;
    end
  end

  // busy register for the second cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= STROBE_IDLE;
    end else begin
      busy_q <= busy_d;
    end
  end

  //==========================================================
  // outputs
  // read address comes straight from the word; the file answers in the same cycle
  assign file_raddr = addr_field;
  // write port to the file registers
  assign file_we = file_we_q;
  assign file_waddr = file_waddr_q;
  assign file_wdata = file_wdata_q;
  // write port to the accumulator
  assign acc_we = acc_we_q;
  assign acc_wdata = acc_wdata_q;
  // zero flag update
  assign zero_we = zero_we_q;
  assign zero_val = zero_val_q;
  // skip and busy markers
  assign skip_nop = skip_q;
  assign busy = busy_q;
endmodule
`default_nettype wire

// file: hw/iie_pkg.sv
// constants for the increment instruction execution block
//==========================================================
package iie_pkg;
  //==========================================================
  // instruction word layout
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int OPC_MSB = 11;
  localparam int OPC_LSB = 6;
  localparam int DEST_BIT = 5;
  // opcode field values (bits 11..6)
  localparam logic [5:0] OPC_INC = 6'h0a;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
endpackage

// file: verification/iie_assertions.sv
// checker for the increment execution block
`timescale 1ns/1ns
`default_nettype none
module iie_chk import iie_pkg::*; (input wire logic clk, rst, instr_valid, file_we, acc_we,
  zero_we, zero_val, skip_nop, busy, input wire logic [11:0] instr_word,
  input wire logic [7:0] file_rdata, file_wdata, acc_wdata,
  input wire logic [4:0] file_waddr, file_raddr);
  wire logic take = instr_valid && !skip_nop;
  wire logic go_i = take && instr_word[11:6] == OPC_INC;
  wire logic go_s = take && instr_word[11:6] == OPC_INC_SKIP;
  wire logic [7:0] s = file_rdata + 8'h01;
  wire logic z = s == 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence skip_seq; skip_nop ##1 !skip_nop; endsequence
  a_inc_zero: assert property (go_i |=> zero_we && zero_val == $past(z)) else $error("zero");
  a_skip_flags: assert property (go_s |=> !zero_we) else $error("flags");
  a_dest_acc: assert property ((go_i || go_s) && !instr_word[5] |=> acc_we && !file_we
    && acc_wdata == $past(s)) else $error("acc");
  a_dest_file: assert property ((go_i || go_s) && instr_word[5] |=> file_we && !acc_we
    && file_wdata == $past(s)) else $error("file");
  a_skip_taken: assert property (go_s && z |=> skip_seq) else $error("skip");
  a_skip_none: assert property (go_s && !z |=> !skip_nop) else $error("noskip");
  a_wrap_zero: assert property (go_i && file_rdata == 8'hff |=> zero_val) else $error("wrap");
  a_busy_two: assert property (go_s && z |=> busy ##1 !busy) else $error("busy");
  a_waddr_same: assert property ((go_i || go_s) && instr_word[5] |=>
    file_waddr == $past(instr_word[4:0])) else $error("waddr");
  a_raddr_field: assert property (file_raddr == instr_word[4:0]) else $error("raddr");
  a_drop_word: assert property (skip_nop |=> !file_we && !acc_we && !zero_we)
    else $error("drop");
  a_idle_quiet: assert property (!(go_i || go_s) |=> !file_we && !acc_we && !zero_we
    && !skip_nop) else $error("idle");
endmodule
bind iie_exec iie_chk chk_u(.clk(clk), .rst(rst), .instr_valid(instr_valid), .file_we(file_we),
  .acc_we(acc_we), .zero_we(zero_we), .zero_val(zero_val), .skip_nop(skip_nop), .busy(busy),
  .instr_word(instr_word), .file_rdata(file_rdata), .file_wdata(file_wdata),
  .acc_wdata(acc_wdata), .file_waddr(file_waddr), .file_raddr(file_raddr));
`default_nettype wire

// file: verification/iie_exec_tb.sv
// self-checking bench for the increment execution block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin samples_checked++; if ((a)!==(b)) begin failures++; \
  $display("unexpected t=%0t %h %h", $time, a, b); end end
module iie_exec_tb import iie_pkg::*;;
  logic clk = 0, rst = 1, v = 0, fwe, awe, zwe, zv, sk, bz;
  logic [11:0] w = 0;
  logic [7:0] rd = 0, wd, ad;
  logic [4:0] ra, wa;
  int failures = 0, samples_checked = 0, cyc = 0;
  iie_exec dut_u(.clk, .rst, .instr_valid(v), .instr_word(w), .file_rdata(rd), .file_raddr(ra),
    .file_we(fwe), .file_waddr(wa), .file_wdata(wd), .acc_we(awe), .acc_wdata(ad),
    .zero_we(zwe), .zero_val(zv), .skip_nop(sk), .busy(bz));
  initial forever #20 clk = ~clk;
  // one word issued for a cycle, then valid set to nv
  task issue(input logic [11:0] x, input logic [7:0] r, input logic nv);
    @(posedge clk) #1 v = 1; w = x; rd = r;
    @(posedge clk) #1 v = nv;
  endtask
  task complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task t_inc; issue(12'h280, 8'hff, 0);
    `CHK({awe, ad, fwe, zwe, zv}, {1'b1, 8'h00, 1'b0, 1'b1, 1'b1})
    $display("t_inc done"); endtask
  task t_file; issue(12'h2bf, 8'h41, 0);
    `CHK({fwe, wa, wd, awe, zwe, zv}, {1'b1, 5'h1f, 8'h42, 1'b0, 1'b1, 1'b0})
    `CHK(ra, 5'h1f)
    $display("t_file done"); endtask
  task t_skip; issue(12'h3e3, 8'hff, 1);
    `CHK({fwe, wa, wd, zwe, sk, bz}, {1'b1, 5'h03, 8'h00, 1'b0, 1'b1, 1'b1})
    @(posedge clk) #1 v = 0;
    `CHK({fwe, awe, sk, bz}, 4'h0)
    $display("t_skip done"); endtask
  task t_nosk; issue(12'h3c3, 8'h10, 0);
    `CHK({awe, ad, fwe, zwe, sk}, {1'b1, 8'h11, 1'b0, 1'b0, 1'b0})
    $display("t_nosk done"); endtask
  task t_refuse; issue(12'h2c3, 8'hff, 0);
    `CHK({fwe, awe, zwe, sk, bz}, 5'h00)
    @(posedge clk) #1 w = 12'h3ff; rd = 8'hff;
    @(posedge clk) #1;
    `CHK({fwe, awe, zwe, sk, bz}, 5'h00)
    $display("t_refuse done"); endtask
  task t_back;
    @(posedge clk) #1 v = 1; w = 12'h2a5; rd = 8'h7f;
    @(posedge clk) #1 w = 12'h3c5; rd = 8'h00;
    `CHK({fwe, wa, wd, zwe, zv}, {1'h1, 5'h05, 8'h80, 1'h1, 1'h0})
    @(posedge clk) #1 v = 0;
    `CHK({awe, ad, zwe, sk, bz}, {1'h1, 8'h01, 1'h0, 1'h0, 1'h0})
    $display("t_back done"); endtask
  task t_rst;
    @(posedge clk) #1 v = 1; w = 12'h3ff; rd = 8'hff; rst = 1;
    @(posedge clk) #1 rst = 0; v = 0;
    `CHK({fwe, awe, zwe, sk, bz}, 5'h00)
    @(posedge clk) #1;
    `CHK({fwe, awe, zwe, sk, bz}, 5'h00)
    $display("t_rst done"); endtask
  always @(posedge clk) if (++cyc > 200) begin failures++; complete_run; end
  initial begin repeat (10) @(posedge clk); #1 rst = 0;
    `CHK({fwe, awe, zwe, sk, bz}, 5'h00)
    t_inc; t_file; t_skip; t_nosk; t_refuse; t_back; t_rst; t_inc; complete_run; end
endmodule
`default_nettype wire
